// File: rtl/vid_mode_latch_current_balance.sv
// vid_mode_latch_current_balance: operating-mode latch, regulator enables and channel current balance
// assumes enable and mode select are asynchronous pins; samples arrive on the system clock with a cycle strobe
//
// Overview of operation
// - enable low keeps core and bridge regulators disabled
// - while enable low, mode select is sampled continuously, nothing latched
// - mode select captured into the mode latch on enable rising edge
// - mode select low at capture selects serial code operation
// - mode select high at capture selects parallel code operation
// - every active channel sampled once each switching cycle
// - cycle average is sum of active samples over active count
// - each channel error is sample minus average, filtered, adjusts pulse width
// - each active channel corrected by its own filtered error, driving errors to zero
// - per-channel path replicated; inactive channels' paths held inactive
// - active count from detection straps, one to four channels
`default_nettype none
module vid_mode_latch_current_balance #(
	parameter int CHANNELS = vml_pkg::MAX_CHANNELS,
	parameter int CURRENT_W = vml_pkg::CURRENT_W,
	parameter int PULSE_W = vml_pkg::PULSE_W
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic enable_i,
	input wire logic mode_select_pin_i,
	input wire logic [CHANNELS-2:0] channel_unused_strap_i,
	input wire logic cycle_start_i,
	input wire logic [CHANNELS*CURRENT_W-1:0] sensed_channel_current_i,
	input wire logic [PULSE_W-1:0] error_amp_output_i,
	output vml_pkg::regulator_ctrl_t regulator_ctrl_o,
	output logic [2:0] active_count_o,
	output logic [CURRENT_W-1:0] cycle_average_current_o,
	output vml_pkg::channel_out_t [CHANNELS-1:0] channel_o
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] enable_sync;
	logic [1:0] select_sync;
	logic [CHANNELS-2:0] strap_meta;
	logic [CHANNELS-2:0] strap_sync;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			enable_sync <= 2'h0;
			select_sync <= 2'h0;
			strap_meta <= '0;
			strap_sync <= '0;
		end else begin
			enable_sync <= {enable_sync[0], enable_i};
			select_sync <= {select_sync[0], mode_select_pin_i};
			strap_meta <= channel_unused_strap_i;
			strap_sync <= strap_meta;
		end
	end

	wire enable_level = enable_sync[1];
	wire select_level = select_sync[1];

	////////////////////////////////////////////////////////////////////////////
	// enable state and mode latch
	vml_pkg::en_state_t state;
	vml_pkg::en_state_t next_state;
	vml_pkg::op_mode_t mode;
	vml_pkg::op_mode_t next_mode;

	wire enable_rise = (state == vml_pkg::ST_DISABLED) && enable_level;
	wire captured_mode_is_parallel = select_level;

	always_comb begin
		next_state = state;
		case (state)
			vml_pkg::ST_DISABLED: begin
				if (enable_level) begin
					next_state = vml_pkg::ST_ENABLED;
				end
			end
			vml_pkg::ST_ENABLED: begin
				if (!enable_level) begin
					next_state = vml_pkg::ST_DISABLED;
				end
			end
			default: begin
				next_state = vml_pkg::ST_DISABLED;
			end
		endcase
	end

	always_comb begin
		next_mode = mode;
		if (enable_rise) begin
			next_mode = captured_mode_is_parallel ? vml_pkg::MODE_PARALLEL : vml_pkg::MODE_SERIAL;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= vml_pkg::ST_DISABLED;
			mode <= vml_pkg::MODE_NONE;
		end else begin
			state <= next_state;
			mode <= next_mode;
		end
	end

	wire running = (state == vml_pkg::ST_ENABLED) && enable_level;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			regulator_ctrl_o <= '0;
		end else begin
			regulator_ctrl_o.core_enable <= running && (next_mode != vml_pkg::MODE_NONE);
			regulator_ctrl_o.bridge_enable <= running && (next_mode == vml_pkg::MODE_SERIAL);
			regulator_ctrl_o.serial_code_mode <= (next_mode == vml_pkg::MODE_SERIAL);
			regulator_ctrl_o.parallel_code_mode <= (next_mode == vml_pkg::MODE_PARALLEL);
			regulator_ctrl_o.mode_latched <= (next_mode != vml_pkg::MODE_NONE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// active channel count from straps; a strap high removes that channel and all above
	logic [2:0] active_count;
	logic [CHANNELS-1:0] active_mask;

	always_comb begin
		active_count = vml_pkg::CHANNELS_MIN;
		for (int i = 0; i < CHANNELS - 1; i++) begin
			if (!strap_sync[i] && (active_count == 3'(i + 1))) begin
				active_count = 3'(i + 2);
			end
		end
		if (active_count > vml_pkg::CHANNELS_MAX) begin
			active_count = vml_pkg::CHANNELS_MAX;
		end
	end

	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			active_mask[i] = running && (3'(i) < active_count);
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			active_count_o <= vml_pkg::CHANNELS_MIN;
		end else begin
			active_count_o <= active_count;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-cycle sample capture and average
	logic [CHANNELS*CURRENT_W-1:0] samples;
	logic [CURRENT_W+2:0] sample_sum;
	logic [CURRENT_W+2:0] average_wide;
	logic sample_valid;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			samples <= '0;
			sample_valid <= 1'b0;
		end else begin
			sample_valid <= cycle_start_i && running;
			if (cycle_start_i) begin
				samples <= sensed_channel_current_i;
			end
		end
	end

	always_comb begin
		sample_sum = '0;
		for (int i = 0; i < CHANNELS; i++) begin
			if (active_mask[i]) begin
				sample_sum = sample_sum + (CURRENT_W+3)'(samples[i*CURRENT_W +: CURRENT_W]);
			end
		end
	end

	assign average_wide = (active_count == 3'h0) ? '0 : sample_sum / (CURRENT_W+3)'(active_count);

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cycle_average_current_o <= '0;
		end else if (sample_valid) begin
			cycle_average_current_o <= average_wide[CURRENT_W-1:0];
		end
	end

	logic balance_strobe;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			balance_strobe <= 1'b0;
		end else begin
			balance_strobe <= sample_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// replicated balance paths
	logic signed [vml_pkg::ERROR_W-1:0] chan_error [CHANNELS];
	logic [PULSE_W-1:0] chan_pulse [CHANNELS];
	logic [CHANNELS-1:0] chan_active;

	for (genvar g = 0; g < CHANNELS; g++) begin : gen_channel
		balance_channel #(
			.CURRENT_W(CURRENT_W),
			.PULSE_W(PULSE_W),
			.ERROR_W(vml_pkg::ERROR_W)
		) u_channel (
			.clock_i(clock_i),
			.rstn_i(rstn_i),
			.active_i(active_mask[g]),
			.sample_i(balance_strobe),
			.sensed_channel_current_i(samples[g*CURRENT_W +: CURRENT_W]),
			.cycle_average_current_i(cycle_average_current_o),
			.error_amp_output_i(error_amp_output_i),
			.balance_error_o(chan_error[g]),
			.pulse_width_o(chan_pulse[g])
		);
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			chan_active <= '0;
		end else begin
			chan_active <= active_mask;
		end
	end

	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			channel_o[i].active = chan_active[i];
			channel_o[i].balance_error = chan_error[i];
			channel_o[i].pulse_width = chan_pulse[i];
		end
	end
endmodule : vid_mode_latch_current_balance
`default_nettype wire

// File: rtl/vml_pkg.sv
// package: shared constants and carrier types for the mode latch and current balance block
// assumes a 100 MHz system clock and unsigned sampled channel currents
`default_nettype none
package vml_pkg;
	localparam int CLOCK_MHZ = 100;
	localparam int SETUP_NS = 1000;
	localparam int SETUP_CYCLES = (SETUP_NS * CLOCK_MHZ + 999) / 1000;
	localparam int MAX_CHANNELS = 4;
	localparam int CURRENT_W = 12;
	localparam int PULSE_W = 12;
	localparam int ERROR_W = CURRENT_W + 1;
	localparam int FILTER_SHIFT = 2;
	localparam logic [2:0] CHANNELS_MIN = 3'h1;
	localparam logic [2:0] CHANNELS_MAX = 3'h4;

	typedef enum logic [1:0] {
		MODE_NONE = 2'h0,
		MODE_SERIAL = 2'h1,
		MODE_PARALLEL = 2'h3
	} op_mode_t;

	typedef enum logic [1:0] {
		ST_DISABLED = 2'h0,
		ST_ENABLED = 2'h1
	} en_state_t;

	typedef struct packed {
		logic core_enable;
		logic bridge_enable;
		logic serial_code_mode;
		logic parallel_code_mode;
		logic mode_latched;
	} regulator_ctrl_t;

	typedef struct packed {
		logic active;
		logic signed [ERROR_W-1:0] balance_error;
		logic [PULSE_W-1:0] pulse_width;
	} channel_out_t;
endpackage : vml_pkg
`default_nettype wire

// File: rtl/balance_channel.sv
// balance_channel: one channel's error filter and corrected pulse width
// assumes the sample strobe comes from the same clock domain
`default_nettype none
module balance_channel #(
	parameter int CURRENT_W = vml_pkg::CURRENT_W,
	parameter int PULSE_W = vml_pkg::PULSE_W,
	parameter int ERROR_W = vml_pkg::ERROR_W
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic active_i,
	input wire logic sample_i,
	input wire logic [CURRENT_W-1:0] sensed_channel_current_i,
	input wire logic [CURRENT_W-1:0] cycle_average_current_i,
	input wire logic [PULSE_W-1:0] error_amp_output_i,
	output logic signed [ERROR_W-1:0] balance_error_o,
	output logic [PULSE_W-1:0] pulse_width_o
);
	logic signed [ERROR_W-1:0] raw_error;
	logic signed [ERROR_W+1:0] filtered;
	logic signed [ERROR_W+1:0] next_filtered;
	logic signed [ERROR_W+1:0] corrected;
	logic [PULSE_W-1:0] next_pulse;

	// positive error means this channel carries more than the average
	assign raw_error = $signed({1'b0, sensed_channel_current_i}) - $signed({1'b0, cycle_average_current_i});
	assign next_filtered = filtered + ((($signed({{2{raw_error[ERROR_W-1]}}, raw_error})) - filtered)
		>>> vml_pkg::FILTER_SHIFT);
	// a channel above average gets a shorter pulse
	assign corrected = $signed((ERROR_W+2)'(error_amp_output_i)) - filtered;
	// clamp to the pulse range: below zero gives no pulse, above full scale gives full scale
	assign next_pulse = corrected[ERROR_W+1] ? '0 :
		((|corrected[ERROR_W:PULSE_W]) ? {PULSE_W{1'b1}} : corrected[PULSE_W-1:0]);

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			filtered <= '0;
			balance_error_o <= '0;
			pulse_width_o <= '0;
		end else if (!active_i) begin
			filtered <= '0;
			balance_error_o <= '0;
			pulse_width_o <= '0;
		end else if (sample_i) begin
			filtered <= next_filtered;
			balance_error_o <= raw_error;
			pulse_width_o <= next_pulse;
		end
	end
endmodule : balance_channel
`default_nettype wire

// File: sim/vml_properties.sv
// checker: port-level properties of the mode latch and balance block
// assumes it is bound to the top module
`default_nettype none
module vml_properties #(
	parameter int CHANNELS = 4,
	parameter int CURRENT_W = 12,
	parameter int PULSE_W = 12
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic enable_i,
	input wire logic mode_select_pin_i,
	input wire logic cycle_start_i,
	input wire vml_pkg::regulator_ctrl_t regulator_ctrl_o,
	input wire logic [2:0] active_count_o,
	input wire logic [CURRENT_W-1:0] cycle_average_current_o,
	input wire vml_pkg::channel_out_t [CHANNELS-1:0] channel_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	property p_off_low;
		!enable_i [*5] |-> !regulator_ctrl_o.core_enable && !regulator_ctrl_o.bridge_enable
			&& channel_o[0].pulse_width == '0;
	endproperty
	a_off_low: assert property (p_off_low) else $error("regulator on while enable low");
	property p_hold;
		enable_i [*7] |=> $stable(regulator_ctrl_o);
	endproperty
	a_hold: assert property (p_hold) else $error("mode moved while enabled");
	property p_serial;
		$rose(enable_i) && !mode_select_pin_i ##1 enable_i [*5] |-> regulator_ctrl_o.serial_code_mode
			&& !regulator_ctrl_o.parallel_code_mode && regulator_ctrl_o.mode_latched;
	endproperty
	a_serial: assert property (p_serial) else $error("serial mode not latched");
	property p_parallel;
		$rose(enable_i) && mode_select_pin_i ##1 enable_i [*5] |-> regulator_ctrl_o.parallel_code_mode
			&& !regulator_ctrl_o.serial_code_mode && regulator_ctrl_o.core_enable;
	endproperty
	a_parallel: assert property (p_parallel) else $error("parallel mode not latched");
	property p_reset;
		$rose(rstn_i) |-> regulator_ctrl_o == '0;
	endproperty
	a_reset: assert property (p_reset) else $error("control not clear after reset");
	property p_count;
		active_count_o inside {[3'h1:3'h4]};
	endproperty
	a_count: assert property (p_count) else $error("channel count out of range");
	property p_inactive;
		channel_o[3].active |-> active_count_o == 3'h4 && channel_o[0].active;
	endproperty
	a_inactive: assert property (p_inactive) else $error("inactive channel path running");
	property p_avg_hold;
		(enable_i && !cycle_start_i) [*6] |=> $stable(cycle_average_current_o);
	endproperty
	a_avg_hold: assert property (p_avg_hold) else $error("average moved without strobe");
	c_serial: cover property (regulator_ctrl_o.serial_code_mode);
	c_parallel: cover property (regulator_ctrl_o.parallel_code_mode);
	c_strobe: cover property (cycle_start_i && regulator_ctrl_o.core_enable);
endmodule : vml_properties
bind vid_mode_latch_current_balance vml_properties #(.CHANNELS(CHANNELS), .CURRENT_W(CURRENT_W),
	.PULSE_W(PULSE_W)) chk (.clock_i(clock_i), .rstn_i(rstn_i), .enable_i(enable_i),
	.mode_select_pin_i(mode_select_pin_i), .cycle_start_i(cycle_start_i),
	.regulator_ctrl_o(regulator_ctrl_o), .active_count_o(active_count_o),
	.cycle_average_current_o(cycle_average_current_o), .channel_o(channel_o));
`default_nettype wire

// File: sim/board_enable_model.sv
// board side: system enable logic and mode select strap
// assumes the bench asks for enable and select levels
`default_nettype none
module board_enable_model (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic want_enable_i,
	input wire logic want_select_i,
	output logic enable_o,
	output logic mode_select_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int settle;
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			enable_o <= 1'b0;
			mode_select_o <= 1'b0;
			settle <= 0;
		end else if (!want_enable_i) begin
			enable_o <= 1'b0;
			mode_select_o <= want_select_i;
			settle <= 0;
		end else if (!enable_o) begin
			settle <= settle + 1;
			enable_o <= settle >= vml_pkg::SETUP_CYCLES;
		end else begin
			mode_select_o <= want_select_i;
		end
	end
endmodule : board_enable_model
`default_nettype wire

// File: sim/vid_mode_latch_current_balance_tb.sv
// bench: mode latch and current balance scenarios
// assumes the board model drives enable and select
`default_nettype none
module vid_mode_latch_current_balance_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_i = 0, rstn_i = 0, want_en = 0, want_sel = 0, cyc = 0;
	logic [2:0] strap = 3'h0, cnt;
	logic [47:0] cur = {12'h124, 12'he4, 12'ha4, 12'h064};
	logic [11:0] eamp = 12'h800, avg;
	wire logic enable, sel;
	vml_pkg::regulator_ctrl_t ctrl;
	vml_pkg::channel_out_t [3:0] ch;
	int fails = 0, total_checks = 0;
	always #5 clock_i = ~clock_i;
	board_enable_model partner (.clock_i(clock_i), .rstn_i(rstn_i), .want_enable_i(want_en),
		.want_select_i(want_sel), .enable_o(enable), .mode_select_o(sel));
	vid_mode_latch_current_balance uut (.clock_i(clock_i), .rstn_i(rstn_i), .enable_i(enable),
		.mode_select_pin_i(sel), .channel_unused_strap_i(strap), .cycle_start_i(cyc),
		.sensed_channel_current_i(cur), .error_amp_output_i(eamp), .regulator_ctrl_o(ctrl),
		.active_count_o(cnt), .cycle_average_current_o(avg), .channel_o(ch));
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : step
	task power(input logic s, input logic [2:0] st);
		want_en = 0;
		step(6);
		strap = st;
		want_sel = s;
		step(4);
		want_en = 1;
		for (int i = 0; i < 300 && ctrl.core_enable !== 1'b1; i++) step(1);
		step(2);
	endtask : power
	task t_mode(input logic s);
		power(s, 3'h0);
		check("serial", ctrl.serial_code_mode, !s);
		check("parallel", ctrl.parallel_code_mode, s);
		check("latched", ctrl.mode_latched, 1'b1);
		check("core on", ctrl.core_enable, 1'b1);
		check("bridge on", ctrl.bridge_enable, !s);
		want_sel = !s;
		step(8);
		check("held", ctrl.parallel_code_mode, s);
		want_en = 0;
		step(6);
		check("core off", ctrl.core_enable, 1'b0);
		check("bridge off", ctrl.bridge_enable, 1'b0);
	endtask : t_mode
	task t_bal(input logic [2:0] st, input int n);
		int sum;
		sum = 0;
		power(1'b1, st);
		check("count", cnt, n[2:0]);
		// two strobes: the pulse follows the filtered error one strobe late
		repeat (2) begin
			cyc = 1;
			step(1);
			cyc = 0;
			step(5);
		end
		for (int i = 0; i < n; i++) sum += 100 + 64 * i;
		check("average", avg, 16'(sum / n));
		check("error", ch[0].balance_error, 16'(100 - sum / n));
		for (int i = 0; i < 4; i++) begin
			check("active", ch[i].active, i < n);
			if (i >= n) check("idle error", ch[i].balance_error, 16'h0);
		end
		check("low pulse", ch[0].pulse_width > eamp, n > 1);
		check("high pulse", ch[n-1].pulse_width < eamp, n > 1);
	endtask : t_bal
	task close_out();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	initial begin
		#100000;
		fails++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge clock_i);
		#1 rstn_i = 1;
		check("reset ctrl", ctrl, 16'h0);
		check("reset count", cnt, 16'h1);
		t_mode(1'b1);
		t_mode(1'b0);
		t_mode(1'b1);
		t_bal(3'h0, 4);
		t_bal(3'h4, 3);
		t_bal(3'h6, 2);
		t_bal(3'h7, 1);
		close_out();
	end
endmodule : vid_mode_latch_current_balance_tb
`default_nettype wire
